// ### verilog/viu_top.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module viu_top (
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [viu_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [viu_pkg::DAT_W-1:0]   wb_dat_i,
	output logic      [viu_pkg::DAT_W-1:0]   wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        cmp_zero_out,
	input  wire logic                        cmp_one_out,
	input  wire logic                        ext_irq_pin,
	input  wire logic                        timer_zero_ovf,
	input  wire logic                        timer_one_ovf,
	input  wire logic                        conv_done,
	input  wire logic                        halt_mode,
	input  wire logic [viu_pkg::PC_W-1:0]    cur_pc,
	input  wire logic                        call_stb,
	input  wire logic                        return_from_sub_stb,
	input  wire logic                        return_from_irq_stb,
	output logic                             vec_stb,
	output logic      [viu_pkg::PC_W-1:0]    vec_addr,
	output logic                             ret_stb,
	output logic      [viu_pkg::PC_W-1:0]    ret_pc,
	output logic                             wake
);
	localparam int NS = viu_pkg::NSRC;
	localparam int PW = viu_pkg::PC_W;
	localparam int FL = viu_pkg::FLAG_LSB;
	localparam int E1 = viu_pkg::FIRST_EN_LSB;
	localparam int E2 = viu_pkg::SECOND_EN_LSB;

	typedef struct packed {
		logic                          ack;
		logic [viu_pkg::DAT_W-1:0]     rdat;
		logic [viu_pkg::PHASE_W-1:0]   phase;
		logic                          master_irq_enable;
		logic [NS-1:0]                 en;
		logic [NS-1:0]                 flg;
		logic                          vec_stb;
		logic [PW-1:0]                 vec_addr;
		logic                          ret_stb;
		logic [PW-1:0]                 ret_pc;
		logic                          wake;
	} viu_state_t;

	viu_state_t s_r;
	viu_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// True when the byte address selects the given word index.
	function automatic logic reg_hit(
		input logic [viu_pkg::ADR_W-1:0] adr,
		input logic [5:0]                idx
	);
		reg_hit = (adr[1:0] == 2'h0) && (adr[7:2] == idx);
	endfunction

	// Lowest numbered pending source wins.
	function automatic logic [2:0] pick(input logic [NS-1:0] r);
		pick = 3'h0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (r[i]) begin
				pick = 3'(i);
			end
		end
	endfunction

	// Service location of each source.
	function automatic logic [PW-1:0] vec_of(input logic [2:0] src);
		unique case (src)
			viu_pkg::SRC_CMP0: vec_of = viu_pkg::VEC_CMP0;
			viu_pkg::SRC_CMP1: vec_of = viu_pkg::VEC_CMP1;
			viu_pkg::SRC_EXT:  vec_of = viu_pkg::VEC_EXT;
			viu_pkg::SRC_TMR0: vec_of = viu_pkg::VEC_TMR0;
			viu_pkg::SRC_TMR1: vec_of = viu_pkg::VEC_TMR1;
			viu_pkg::SRC_CONV: vec_of = viu_pkg::VEC_CONV;
			default:           vec_of = viu_pkg::VEC_CMP0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sources and stack.

	logic [2:0]    pin_fall;
	logic [NS-1:0] ev;
	logic [PW-1:0] stk_top;
	logic          stk_full;
	logic [3:0]    stk_depth;

	// Comparator outputs and the pin come from outside the clock domain.
	viu_edge #(
		.N (3)
	) u_edge (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  ({ext_irq_pin, cmp_one_out, cmp_zero_out}),
		.fall    (pin_fall)
	);

	// Falling edges and internal pulses form the event vector.
	assign ev = {conv_done, timer_one_ovf, timer_zero_ovf,
		pin_fall};

	logic          seq_busy;
	logic          tick;
	logic [NS-1:0] req;
	logic [2:0]    win;
	logic          take;
	logic          pop;
	logic [NS-1:0] clr;

	// A call or return owns the stack this cycle; entry waits four phases for the next tick.
	assign seq_busy = call_stb | return_from_sub_stb | return_from_irq_stb;
	assign tick = (s_r.phase == viu_pkg::PHASE_TICK);
	assign req = s_r.flg & s_r.en;
	assign win = pick(req);
	// Master enable gates every source; the flags keep latching.
	assign take = tick & s_r.master_irq_enable & (|req)
		& ~stk_full & ~seq_busy;
	assign pop = return_from_sub_stb | return_from_irq_stb;
	assign clr = take ? (6'h01 << win) : '0;

	// Only the program counter goes on the stack at entry.
	viu_stack #(
		.LEVELS (viu_pkg::STACK_LEVELS),
		.W      (PW)
	) u_stack (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.push    (take | call_stb),
		.pop     (pop),
		.push_pc (cur_pc),
		.top_pc  (stk_top),
		.full    (stk_full),
		.depth   (stk_depth)
	);

	////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic       bus_req;
	logic       wr_go;
	logic       wr_first;
	logic       wr_second;
	logic [7:0] wb_byte;
	logic [7:0] rd_byte;

	// Writes land at the edge where the master sees the acknowledge.
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_go = bus_req & wb_we_i & s_r.ack & wb_sel_i[0];
	assign wr_first = wr_go & reg_hit(wb_adr_i, viu_pkg::IDX_FIRST);
	assign wr_second = wr_go & reg_hit(wb_adr_i, viu_pkg::IDX_SECOND);
	assign wb_byte = wb_dat_i[7:0];

	// Read mux; unmapped words answer with zero.
	always_comb begin
		rd_byte = 8'h00;
		if (reg_hit(wb_adr_i, viu_pkg::IDX_FIRST)) begin
			rd_byte[viu_pkg::BIT_MASTER_EN] = s_r.master_irq_enable;
			rd_byte[E1 +: 3] = s_r.en[2:0];
			rd_byte[FL +: 3] = s_r.flg[2:0];
		end else if (reg_hit(wb_adr_i, viu_pkg::IDX_SECOND)) begin
			rd_byte[E2 +: 3] = s_r.en[5:3];
			rd_byte[FL +: 3] = s_r.flg[5:3];
		end else if (reg_hit(wb_adr_i, viu_pkg::IDX_STAT)) begin
			rd_byte[viu_pkg::STAT_DEPTH_LSB +: 4] = stk_depth;
			rd_byte[viu_pkg::STAT_FULL_BIT] = stk_full;
			rd_byte[viu_pkg::STAT_HELD_BIT] =
				stk_full & s_r.master_irq_enable & (|req);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Priority inside one cycle: software write, then acknowledge and
	// return, then hardware events, so a source event is never lost.
	always_comb begin
		s_nxt = s_r;
		s_nxt.phase = s_r.phase + 2'h1;
		s_nxt.vec_stb = 1'b0;
		s_nxt.ret_stb = 1'b0;
		s_nxt.ack = bus_req & ~s_r.ack;
		if (bus_req && !s_r.ack) begin
			s_nxt.rdat = {24'h000000, rd_byte};
		end
		// Seven enable bits and six writable flags.
		if (wr_first) begin
			s_nxt.master_irq_enable =
				wb_byte[viu_pkg::BIT_MASTER_EN];
			s_nxt.en[2:0] = wb_byte[E1 +: 3];
			s_nxt.flg[2:0] = wb_byte[FL +: 3];
		end
		if (wr_second) begin
			s_nxt.en[5:3] = wb_byte[E2 +: 3];
			s_nxt.flg[5:3] = wb_byte[FL +: 3];
		end
		// Entry blocks further entries until software or an interrupt return.
		if (take) begin
			s_nxt.master_irq_enable = 1'b0;
			s_nxt.vec_stb = 1'b1;
			s_nxt.vec_addr = vec_of(win);
		end
		if (pop) begin
			s_nxt.ret_stb = 1'b1;
			s_nxt.ret_pc = stk_top;
		end
		// Of the two returns, only the interrupt return restores the master enable.
		if (return_from_irq_stb) begin
			s_nxt.master_irq_enable = 1'b1;
		end
		// Flags are sticky; set wins over any clear in the same cycle.
		s_nxt.flg = (s_nxt.flg & ~clr) | ev;
		// A flag already set before halt does not wake again.
		s_nxt.wake = halt_mode & (|(ev & ~s_r.flg));
	end

	// Single register stage for all state.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.master_irq_enable <= viu_pkg::RST_MASTER;
			s_r.en <= viu_pkg::RST_EN;
			s_r.flg <= viu_pkg::RST_FLAG;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o = s_r.rdat;
	assign wb_ack_o = s_r.ack;
	assign vec_stb = s_r.vec_stb;
	assign vec_addr = s_r.vec_addr;
	assign ret_stb = s_r.ret_stb;
	assign ret_pc = s_r.ret_pc;
	assign wake = s_r.wake;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	full_hold_a: assert property (
		stk_full && !pop |=> !s_r.vec_stb)
		else $error("vectored while stack full");

	held_serve_a: assert property (
		stk_full && tick && s_r.master_irq_enable && (|req) && !seq_busy
		##1 return_from_sub_stb && !call_stb && !wr_go
		|-> ##4 s_r.vec_stb)
		else $error("held request not served after return");

	emi_clear_a: assert property (
		s_r.vec_stb |-> !s_r.master_irq_enable || $past(return_from_irq_stb))
		else $error("master enable left set on entry");

	cmp0_vec_a: assert property (
		take && req[viu_pkg::SRC_CMP0] |=> s_r.vec_addr == viu_pkg::VEC_CMP0)
		else $error("wrong vector for comparator zero");

	conv_prio_a: assert property (
		take && req == 6'h30 |=> s_r.vec_addr == viu_pkg::VEC_TMR1)
		else $error("priority order violated");

	flag_ack_a: assert property (
		take && win == viu_pkg::SRC_TMR0 && !timer_zero_ovf
		|=> !s_r.flg[viu_pkg::SRC_TMR0])
		else $error("served flag not cleared");

	irq_ret_a: assert property (
		return_from_irq_stb |=> s_r.master_irq_enable && s_r.ret_stb)
		else $error("irq return did not restore enable");

	sub_ret_a: assert property (
		return_from_sub_stb && !wr_first
		|=> s_r.master_irq_enable == $past(s_r.master_irq_enable))
		else $error("sub return altered master enable");

	tick_only_a: assert property (
		s_r.vec_stb |-> $past(tick))
		else $error("entry outside sampling phase");

	wake_src_a: assert property (
		halt_mode && conv_done && !s_r.flg[viu_pkg::SRC_CONV]
		|=> s_r.wake)
		else $error("no wake from conversion event");

	flag_keep_a: assert property (
		s_r.flg[viu_pkg::SRC_CONV] && !wr_second && !clr[viu_pkg::SRC_CONV]
		|=> s_r.flg[viu_pkg::SRC_CONV])
		else $error("flag dropped by itself");

	ack_pulse_a: assert property (
		bus_req && !s_r.ack |=> s_r.ack ##1 !s_r.ack)
		else $error("bus acknowledge not a single pulse");

	entry_push_a: assert property (
		take |=> stk_depth == $past(stk_depth) + 4'h1)
		else $error("entry did not push the program counter");

	full_latch_a: assert property (
		stk_full && timer_zero_ovf |=> s_r.flg[viu_pkg::SRC_TMR0])
		else $error("request lost while stack full");

	cmp1_vec_a: assert property (
		take && req[2:0] == 3'h2 |=> s_r.vec_addr == viu_pkg::VEC_CMP1)
		else $error("wrong vector for comparator one");

	entry_c: cover property (s_r.vec_stb);
	held_c: cover property (stk_full && (|req) ##[1:20] s_r.vec_stb);
	nest_c: cover property (s_r.vec_stb ##[1:40] s_r.vec_stb);
	wake_c: cover property (s_r.wake);
endmodule
`default_nettype wire

// ### inc/viu_pkg.sv
`default_nettype none
package viu_pkg;
	// Widths of the program counter, bus address and bus data; number of sources and stack levels.
	localparam int PC_W  = 11;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int NSRC  = 6;
	localparam int STACK_LEVELS = 8;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_FIRST  = 6'h0B;
	localparam logic [5:0] IDX_SECOND = 6'h1E;
	localparam logic [5:0] IDX_STAT   = 6'h20;

	// Field positions inside the two control registers.
	localparam int BIT_MASTER_EN = 0;
	localparam int FIRST_EN_LSB  = 1;
	localparam int SECOND_EN_LSB = 0;
	localparam int FLAG_LSB      = 4;

	// Field positions inside the status register.
	localparam int STAT_DEPTH_LSB = 0;
	localparam int STAT_FULL_BIT  = 4;
	localparam int STAT_HELD_BIT  = 5;

	// Source numbers; a lower number wins arbitration.
	localparam logic [2:0] SRC_CMP0 = 3'h0;
	localparam logic [2:0] SRC_CMP1 = 3'h1;
	localparam logic [2:0] SRC_EXT  = 3'h2;
	localparam logic [2:0] SRC_TMR0 = 3'h3;
	localparam logic [2:0] SRC_TMR1 = 3'h4;
	localparam logic [2:0] SRC_CONV = 3'h5;

	// Fixed program locations of the service routines.
	localparam logic [PC_W-1:0] VEC_CMP0 = 11'h004;
	localparam logic [PC_W-1:0] VEC_CMP1 = 11'h008;
	localparam logic [PC_W-1:0] VEC_EXT  = 11'h00C;
	localparam logic [PC_W-1:0] VEC_TMR0 = 11'h010;
	localparam logic [PC_W-1:0] VEC_TMR1 = 11'h014;
	localparam logic [PC_W-1:0] VEC_CONV = 11'h018;

	// Reset values of the control state.
	localparam logic            RST_MASTER = 1'b0;
	localparam logic [NSRC-1:0] RST_EN     = 6'h00;
	localparam logic [NSRC-1:0] RST_FLAG   = 6'h00;

	// Four phases per instruction cycle; requests are taken on one.
	localparam int         PHASE_W    = 2;
	localparam logic [1:0] PHASE_TICK = 2'h1;
endpackage
`default_nettype wire

// ### verilog/viu_edge.sv
`timescale 1ns/10ps
`default_nettype none
module viu_edge #(
	parameter int N = 3
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] pin_in,
	output logic      [N-1:0] fall
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] fall;
	} viu_edge_t;

	viu_edge_t s_r;
	viu_edge_t s_nxt;

	// Only the second stage and later are looked at for the edge.
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = pin_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.fall = s_r.s3 & ~s_r.s2;
	end

	// Reset low so that a pin held low at release gives no edge.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fall = s_r.fall;
endmodule
`default_nettype wire

// ### verilog/viu_stack.sv
`timescale 1ns/10ps
`default_nettype none
module viu_stack #(
	parameter int LEVELS = viu_pkg::STACK_LEVELS,
	parameter int W      = viu_pkg::PC_W
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic                      push,
	input  wire logic                      pop,
	input  wire logic [W-1:0]              push_pc,
	output logic      [W-1:0]              top_pc,
	output logic                           full,
	output logic      [$clog2(LEVELS):0]   depth
);
	localparam int PW = $clog2(LEVELS);

	typedef struct packed {
		logic [LEVELS-1:0][W-1:0] mem;
		logic [PW-1:0]            wp;
		logic [PW:0]              depth;
	} viu_stack_t;

	viu_stack_t s_r;
	viu_stack_t s_nxt;

	// Ring buffer: a push into a full stack overwrites the oldest entry.
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = push_pc;
			s_nxt.wp = s_r.wp + 1'b1;
			if (!full) begin
				s_nxt.depth = s_r.depth + 1'b1;
			end
		end else if (pop && s_r.depth != '0) begin
			s_nxt.wp = s_r.wp - 1'b1;
			s_nxt.depth = s_r.depth - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign top_pc = s_r.mem[PW'(s_r.wp - 1'b1)];
	assign full = (s_r.depth == (PW+1)'(LEVELS));
	assign depth = s_r.depth;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	stack_keep_full_a: assert property (
		full && push |=> full && s_r.wp == $past(s_r.wp) + 1'b1)
		else $error("full stack push did not wrap");
endmodule
`default_nettype wire

// ### testbench/viu_partner.sv
`timescale 1ns/10ps
`default_nettype none
module viu_partner (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [5:0]  fire,
	input  wire logic        do_call,
	input  wire logic        do_rsub,
	input  wire logic        do_rirq,
	input  wire logic [10:0] jump_pc,
	input  wire logic        vec_stb,
	input  wire logic [10:0] vec_addr,
	input  wire logic        ret_stb,
	input  wire logic [10:0] ret_pc,
	output logic             cmp_zero_out,
	output logic             cmp_one_out,
	output logic             ext_irq_pin,
	output logic             timer_zero_ovf,
	output logic             timer_one_ovf,
	output logic             conv_done,
	output logic [10:0]      cur_pc,
	output logic             call_stb,
	output logic             return_from_sub_stb,
	output logic             return_from_irq_stb
);
	logic [2:0][3:0] low_r;
	logic [10:0]     pc_r;
	logic [10:0]     tgt_r;

	////////////////////////////////////////////////////////////////////
	// Pins idle high; an event pulls one low for eight cycles, so it
	// gives exactly one falling edge and a harmless rising edge later.
	assign cmp_zero_out = (low_r[0] == 4'h0);
	assign cmp_one_out  = (low_r[1] == 4'h0);
	assign ext_irq_pin  = (low_r[2] == 4'h0);
	assign cur_pc       = pc_r;

	////////////////////////////////////////////////////////////////////
	// The sequencer holds its program counter still and only jumps on
	// a call, an entry or a return, so every pushed value is known.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_r <= '0;
			pc_r <= 11'h000;
			tgt_r <= 11'h000;
			timer_zero_ovf <= 1'b0;
			timer_one_ovf <= 1'b0;
			conv_done <= 1'b0;
			call_stb <= 1'b0;
			return_from_sub_stb <= 1'b0;
			return_from_irq_stb <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (fire[i])
					low_r[i] <= 4'h8;
				else if (low_r[i] != 4'h0)
					low_r[i] <= low_r[i] - 4'h1;
			end
			timer_zero_ovf <= fire[3];
			timer_one_ovf <= fire[4];
			conv_done <= fire[5];
			call_stb <= do_call;
			return_from_sub_stb <= do_rsub;
			return_from_irq_stb <= do_rirq;
			if (do_call)
				tgt_r <= jump_pc;
			if (call_stb)
				pc_r <= tgt_r;
			else if (vec_stb)
				pc_r <= vec_addr;
			else if (ret_stb)
				pc_r <= ret_pc;
		end
	end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i, rd;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        halt_mode, vec_stb, ret_stb, wake, do_call, do_rsub, do_rirq;
	logic        cmp_zero_out, cmp_one_out, ext_irq_pin, conv_done;
	logic        timer_zero_ovf, timer_one_ovf, call_stb;
	logic        return_from_sub_stb, return_from_irq_stb, seen;
	logic [10:0] cur_pc, vec_addr, ret_pc, jump_pc;
	logic [5:0]  fire;
	logic [3:0]  sel_v;
	int          errors, checked;
	logic [10:0] vecs [6] = '{11'h004, 11'h008, 11'h00C, 11'h010, 11'h014,
		11'h018};
	localparam logic [7:0] a_first  = {viu_pkg::IDX_FIRST, 2'b00};
	localparam logic [7:0] a_second = {viu_pkg::IDX_SECOND, 2'b00};
	localparam logic [7:0] a_stat   = {viu_pkg::IDX_STAT, 2'b00};

	viu_top dut_u (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_zero_out,
		.cmp_one_out, .ext_irq_pin, .timer_zero_ovf, .timer_one_ovf,
		.conv_done, .halt_mode, .cur_pc, .call_stb, .return_from_sub_stb,
		.return_from_irq_stb, .vec_stb, .vec_addr, .ret_stb, .ret_pc, .wake);
	viu_partner partner_u (.sys_clk, .rst_n, .fire, .do_call, .do_rsub,
		.do_rirq, .jump_pc, .vec_stb, .vec_addr, .ret_stb, .ret_pc,
		.cmp_zero_out, .cmp_one_out, .ext_irq_pin, .timer_zero_ovf,
		.timer_one_ovf, .conv_done, .cur_pc, .call_stb,
		.return_from_sub_stb, .return_from_irq_stb);

	////////////////////////////////////////////////////////////////////
	// Expected register images built from enables and pending flags.
	function automatic logic [7:0] first_v(input logic m,
		input logic [5:0] en, input logic [5:0] fl);
		return {1'b0, fl[2:0], en[2:0], m};
	endfunction
	function automatic logic [7:0] second_v(input logic [5:0] en,
		input logic [5:0] fl);
		return {1'b0, fl[5:3], 1'b0, en[5:3]};
	endfunction

	task finish_test;
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// Bus cycle: the request stands until ack is sampled high; a hung
	// slave ends the run rather than stalling it.
	task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel_v;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			finish_test;
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk_val({8'h00, rd}, {8'h00, exp});
	endtask

	// Partner commands last one cycle; sel 0 vector, 1 wake, 2 return.
	task cmd(input logic [5:0] f, input logic c, input logic s,
		input logic r, input logic [10:0] j);
		@(posedge sys_clk);
		fire <= f;
		do_call <= c;
		do_rsub <= s;
		do_rirq <= r;
		jump_pc <= j;
		@(posedge sys_clk);
		fire <= 6'h00;
		do_call <= 1'b0;
		do_rsub <= 1'b0;
		do_rirq <= 1'b0;
	endtask
	task wait_for(input int sel, input int bound);
		seen = 1'b0;
		for (int i = 0; i < bound && !seen; i++) begin
			@(posedge sys_clk);
			seen = sel == 0 ? vec_stb === 1'b1 :
				sel == 1 ? wake === 1'b1 : ret_stb === 1'b1;
		end
	endtask
	task ev(input logic [5:0] f);
		cmd(f, 1'b0, 1'b0, 1'b0, 11'h000);
	endtask
	task ret(input logic irq);
		cmd(6'h00, 1'b0, !irq, irq, 11'h000);
		wait_for(2, 4);
		chk_bit(seen, 1'b1);
	endtask
	task rst;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////
	task t_regs;
		rst;
		rdchk(a_first, 8'h00);
		rdchk(a_second, 8'h00);
		rdchk(a_stat, 8'h00);
		rdchk(8'h04, 8'h00);
		// A write without lane zero selected is acknowledged but ignored.
		sel_v = 4'hE;
		wr(a_first, 8'hFE);
		sel_v = 4'hF;
		rdchk(a_first, 8'h00);
		wr(a_first, 8'hFE);
		rdchk(a_first, 8'h7E);
		rdchk(a_first | 8'h01, 8'h00);
		wr(a_second, 8'hFF);
		rdchk(a_second, 8'h77);
		wr(a_first, 8'h00);
		rdchk(a_first, 8'h00);
		wr(a_second, 8'h00);
	endtask
	task t_each;
		logic [5:0] en;
		rst;
		for (int s = 0; s < 6; s++) begin
			en = 6'h01 << s;
			cmd(6'h00, 1'b1, 1'b0, 1'b0, 11'h120 | 11'(s));
			wr(a_second, second_v(en, 6'h00));
			wr(a_first, first_v(1'b1, en, 6'h00));
			ev(en);
			wait_for(0, 20);
			chk_bit(seen, 1'b1);
			chk_val(vec_addr, vecs[s]);
			rdchk(a_first, first_v(1'b0, en, 6'h00));
			rdchk(a_second, second_v(en, 6'h00));
			ret(!s[0]);
			chk_val(ret_pc, 11'h120 | 11'(s));
			rdchk(a_first, first_v(!s[0], en, 6'h00));
		end
	endtask
	task t_mask;
		rst;
		wr(a_second, second_v(6'h08, 6'h00));
		ev(6'h08);
		wait_for(0, 12);
		chk_bit(seen, 1'b0);
		rdchk(a_second, second_v(6'h08, 6'h08));
		wr(a_second, second_v(6'h00, 6'h08));
		wr(a_first, first_v(1'b1, 6'h00, 6'h00));
		wait_for(0, 12);
		chk_bit(seen, 1'b0);
		wr(a_second, second_v(6'h08, 6'h08));
		wait_for(0, 6);
		chk_bit(seen, 1'b1);
		chk_val(vec_addr, 11'h010);
	endtask
	// Software re-enables inside each routine, so entries nest.
	task t_prio;
		logic [5:0] pend;
		rst;
		pend = 6'h3F;
		wr(a_second, second_v(6'h3F, 6'h00));
		ev(6'h3F);
		wait_for(0, 12);
		rdchk(a_first, first_v(1'b0, 6'h38, pend));
		rdchk(a_second, second_v(6'h3F, pend));
		for (int k = 0; k < 6; k++) begin
			wr(a_first, first_v(1'b1, 6'h3F, pend));
			wait_for(0, 6);
			chk_bit(seen, 1'b1);
			chk_val(vec_addr, vecs[k]);
			pend[k] = 1'b0;
		end
		rdchk(a_second, second_v(6'h3F, 6'h00));
	endtask
	task t_stack;
		rst;
		for (int i = 0; i < 9; i++)
			cmd(6'h00, 1'b1, 1'b0, 1'b0, 11'h200 | 11'(i));
		rdchk(a_stat, 8'h18);
		wr(a_second, second_v(6'h08, 6'h00));
		wr(a_first, first_v(1'b1, 6'h00, 6'h00));
		ev(6'h08);
		wait_for(0, 12);
		chk_bit(seen, 1'b0);
		rdchk(a_second, second_v(6'h08, 6'h08));
		rdchk(a_stat, 8'h38);
		ret(1'b0);
		chk_val(ret_pc, 11'h207);
		wait_for(0, 12);
		chk_bit(seen, 1'b1);
		ret(1'b1);
		for (int i = 6; i >= 0; i--) begin
			ret(1'b0);
			chk_val(ret_pc, 11'h200 | 11'(i));
		end
		rdchk(a_stat, 8'h00);
	endtask
	task t_wake;
		rst;
		halt_mode <= 1'b1;
		for (int s = 0; s < 6; s++) begin
			ev(6'h01 << s);
			wait_for(1, 10);
			chk_bit(seen, 1'b1);
		end
		halt_mode <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Every input is set at time zero, then the scenarios run in turn.
	initial begin
		errors = 0;
		checked = 0;
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		sel_v = 4'hF;
		wb_dat_i = 32'h00000000;
		halt_mode = 1'b0;
		fire = 6'h00;
		do_call = 1'b0;
		do_rsub = 1'b0;
		do_rirq = 1'b0;
		jump_pc = 11'h000;
		t_regs;
		t_each;
		t_mask;
		t_prio;
		t_stack;
		t_wake;
		finish_test;
	end
endmodule
`default_nettype wire
